// ---- common/fsp_pkg.sv ----
// Constants and types for the flash sector protection checker
// Function
// - Program/erase byte 0xff means unprotected
// - Access byte 0xff means unprotected
// - Access bytes at 0x10..; block everything but fetch
// - Access byte overrides program/erase byte
// - Blocked reads return fixed 00h
// - In debug mode only injected instructions and programmer reads checked
// - Core instruction fetch never protected
// - Both bytes 0xff: all allowed except programmer reads
// - Program/erase byte blocks programmer and debug writes
// - Access byte blocks every path except fetch
// - Only programmer whole-chip erase clears protection
// - No code read through in-circuit programming
// - Large variant: eight sectors, 0x00..0x07, 0x10..0x17
// - Small variant: four sectors, 0x00..0x03, 0x10..0x13
// - Violations set flash security error flag
// - Inhibit bytes live in 64-byte ID block
package fsp_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int          FSP_MAX_SECTORS = 8;     // Large variant
   localparam int          FSP_SMALL_SECTORS = 4;   // Small variant
   localparam int          FSP_ADDR_W      = 14;    // 16K program space
   localparam int          FSP_SECT_LSB    = 11;    // 2K sectors
   localparam int          FSP_SECT_MSB    = 13;
   localparam int          FSP_ID_W        = 6;     // 64-byte ID block

   // ------------------------------------------------------------
   // ID block layout and values
   // ------------------------------------------------------------
   localparam logic [5:0]  FSP_PE_BASE     = 6'h00; // Program/erase bytes
   localparam logic [5:0]  FSP_ACC_BASE    = 6'h10; // Access bytes
   localparam logic [7:0]  FSP_UNPROT      = 8'hff; // Unprotected value
   localparam logic [7:0]  FSP_BLOCK_DATA  = 8'h00; // Blocked read value
   localparam logic [7:0]  FSP_RST_BYTE    = 8'h00; // Protected until load

   // ------------------------------------------------------------
   // Access paths and operations
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FSP_PATH_ICP   = 2'h0,   // in_circuit_programming
      FSP_PATH_IAP   = 2'h1,   // in_application_programming
      FSP_PATH_TABLE = 2'h2,   // Code-table read
      FSP_PATH_FETCH = 2'h3    // Core instruction fetch
   } fsp_path_t;

   typedef enum logic [1:0] {
      FSP_OP_READ    = 2'h0,
      FSP_OP_PROG    = 2'h1,
      FSP_OP_ERASE   = 2'h2,
      FSP_OP_CHIPERS = 2'h3    // Whole-chip erase
   } fsp_op_t;

   // Load sequencer states
   typedef enum logic [3:0] {
      FSP_S_IDLE = 4'b0001,
      FSP_S_REQ  = 4'b0010,
      FSP_S_WAIT = 4'b0100,
      FSP_S_RUN  = 4'b1000
   } fsp_state_t;

   // Inhibit byte protected test
   function automatic logic fsp_prot(input logic [7:0] b);
      return b != FSP_UNPROT;
   endfunction

endpackage

// ---- hw/fsp_decide.sv ----
// Per-request protection decision for one access
module fsp_decide
   import fsp_pkg::*;
(
   input  wire logic          pe_prot,
   input  wire logic          acc_prot,
   input  wire fsp_path_t     path,
   input  wire fsp_op_t       op,
   input  wire logic          on_chip_debug_mode,
   input  wire logic          debug_injected_instruction,
   output logic               deny
);

   // ------------------------------------------------------------
   // Decision terms
   // ------------------------------------------------------------
   wire logic is_fetch  = (path == FSP_PATH_FETCH);
   wire logic is_write  = (op == FSP_OP_PROG) || (op == FSP_OP_ERASE);
   // Debug mode without injection is unchecked
   wire logic exempt    = is_fetch ||
                          (on_chip_debug_mode &&
                           !debug_injected_instruction);
   // Injected instruction or programmer: program/erase byte applies
   wire logic pe_path   = (path == FSP_PATH_ICP) ||
                          (on_chip_debug_mode &&
                           debug_injected_instruction);
   // Programmer cannot read code at all
   wire logic icp_read  = (path == FSP_PATH_ICP) &&
                          (op == FSP_OP_READ);
   // Chip erase is the only way out, never denied by protection
   wire logic chip_ers  = (op == FSP_OP_CHIPERS);

   // Access byte wins over program/erase byte; a programmer read is
   // refused even in debug mode, since that path never reads code
   assign deny = icp_read ||
                 (!chip_ers && !exempt &&
                  (acc_prot ||
                   (pe_prot && pe_path &&
                    (is_write || path != FSP_PATH_ICP))));

endmodule

// ---- hw/fsp_top.sv ----
// Flash sector protection checker with ID block loader
module fsp_top
   import fsp_pkg::*;
#(
   parameter int unsigned SECTORS = fsp_pkg::FSP_MAX_SECTORS
)(
   input  wire logic                          clk,
   input  wire logic                          rst_n,
   // Flash request from core, debugger or programmer
   input  wire logic                          req_valid,
   input  wire logic [fsp_pkg::FSP_ADDR_W-1:0] req_addr,
   input  wire fsp_pkg::fsp_path_t            req_path,
   input  wire fsp_pkg::fsp_op_t              req_op,
   input  wire logic                          on_chip_debug_mode,
   input  wire logic                          debug_injected_instruction,
   output logic                               req_ready,
   // Gated request to the flash array
   output logic                               fl_valid,
   output logic [fsp_pkg::FSP_ADDR_W-1:0]     fl_addr,
   output fsp_pkg::fsp_op_t                   fl_op,
   input  wire logic                          fl_done,
   input  wire logic [7:0]                    fl_rdata,
   // Answer to the requester
   output logic                               rsp_valid,
   output logic [7:0]                         rsp_data,
   output logic                               rsp_denied,
   output logic                               flash_security_error_flag,
   input  wire logic                          sec_err_clr,
   // ID block read port used by the loader
   output logic                               id_rd,
   output logic [fsp_pkg::FSP_ID_W-1:0]       id_addr,
   input  wire logic [7:0]                    id_rdata,
   output logic                               load_done
);
   import fsp_pkg::*;

   // ------------------------------------------------------------
   // Inhibit byte store
   // ------------------------------------------------------------
   logic [7:0]   pe_q  [FSP_MAX_SECTORS];  // program_erase_inhibit_byte
   logic [7:0]   acc_q [FSP_MAX_SECTORS];  // access_inhibit_byte
   fsp_state_t   st_q;                     // Loader / run state
   logic [3:0]   ld_idx_q;                 // Bit 3 picks access bank
   logic         busy_q;                   // Request sent to flash
   logic [FSP_ADDR_W-1:0] addr_q;
   fsp_op_t      op_q;
   logic         rd_pend_q;                // Answer waits for read data

   // ------------------------------------------------------------
   // Sector select and decision
   // ------------------------------------------------------------
   // Small variant ignores bit 13 so the map folds to four sectors
   wire logic [2:0] sect_full = req_addr[FSP_SECT_MSB:FSP_SECT_LSB];
   wire logic [2:0] sect      = (SECTORS == FSP_SMALL_SECTORS) ?
                                {1'b0, sect_full[1:0]} :
                                sect_full;
   wire logic       pe_prot   = fsp_prot(pe_q[sect]);
   wire logic       acc_prot  = fsp_prot(acc_q[sect]);
   wire logic       deny;
   wire logic       running   = (st_q == FSP_S_RUN);
   wire logic       take      = running && req_valid && !busy_q;
   wire logic       ld_last   = (ld_idx_q[2:0] ==
                                 3'(SECTORS - 1)) && ld_idx_q[3];
   // Loader address: access bytes in upper bank of page 0
   wire logic [5:0] ld_addr   = (ld_idx_q[3] ? FSP_ACC_BASE : FSP_PE_BASE)
                                + {3'h0, ld_idx_q[2:0]};
   wire logic       chip_ers  = (req_path == FSP_PATH_ICP) &&
                                (req_op == FSP_OP_CHIPERS);

   fsp_decide u_decide (
      .pe_prot                    (pe_prot),
      .acc_prot                   (acc_prot),
      .path                       (req_path),
      .op                         (req_op),
      .on_chip_debug_mode         (on_chip_debug_mode),
      .debug_injected_instruction (debug_injected_instruction),
      .deny                       (deny)
   );

   // ------------------------------------------------------------
   // Loader sequencer: ID block to inhibit store after reset
   // ------------------------------------------------------------
   // Bytes reset to a protected value so nothing slips through
   // before the load finishes; requests wait on req_ready.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q     <= FSP_S_IDLE;
         ld_idx_q <= 4'h0;
         id_rd    <= 1'b0;
         id_addr  <= 6'h00;
         load_done <= 1'b0;
      end else begin
         case (st_q)
            FSP_S_IDLE: begin
               st_q <= FSP_S_REQ;
            end
            FSP_S_REQ: begin
               // Inhibit bytes come from the separate ID block
               id_rd   <= 1'b1;
               id_addr <= ld_addr;
               st_q    <= FSP_S_WAIT;
            end
            FSP_S_WAIT: begin
               // ID block answers while the strobe stands
               id_rd <= 1'b0;
               if (ld_last) begin
                  st_q      <= FSP_S_RUN;
                  load_done <= 1'b1;
               end else begin
                  ld_idx_q <= ld_idx_q[2:0] == 3'(SECTORS - 1) ?
                              4'h8 : ld_idx_q + 4'h1;
                  st_q     <= FSP_S_REQ;
               end
            end
            FSP_S_RUN: begin
               st_q <= FSP_S_RUN;
            end
            default: begin
               st_q <= FSP_S_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Inhibit byte capture and whole-chip erase
   // ------------------------------------------------------------
   // Reset branch loops over every array entry to load the protected value
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < FSP_MAX_SECTORS; i++) begin
            pe_q[i]  <= FSP_RST_BYTE;
            acc_q[i] <= FSP_RST_BYTE;
         end
      end else if (st_q == FSP_S_WAIT) begin
         if (ld_idx_q[3])
            acc_q[ld_idx_q[2:0]] <= id_rdata;
         else
            pe_q[ld_idx_q[2:0]]  <= id_rdata;
      end else if (take && chip_ers) begin
         // Only the programmer's whole-chip erase unprotects
         for (int i = 0; i < FSP_MAX_SECTORS; i++) begin
            pe_q[i]  <= FSP_UNPROT;
            acc_q[i] <= FSP_UNPROT;
         end
      end
   end

   // ------------------------------------------------------------
   // Request gating toward the flash array
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q    <= 1'b0;
         rd_pend_q <= 1'b0;
         fl_valid  <= 1'b0;
         fl_addr   <= '0;
         fl_op     <= FSP_OP_READ;
         addr_q    <= '0;
         op_q      <= FSP_OP_READ;
      end else begin
         if (take && !deny) begin
            // Allowed: forward and hold until flash completes
            busy_q    <= 1'b1;
            fl_valid  <= 1'b1;
            fl_addr   <= req_addr;
            fl_op     <= req_op;
            addr_q    <= req_addr;
            op_q      <= req_op;
            rd_pend_q <= (req_op == FSP_OP_READ);
         end else if (busy_q && fl_done) begin
            busy_q    <= 1'b0;
            fl_valid  <= 1'b0;
            rd_pend_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Answers to the requester
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid  <= 1'b0;
         rsp_data   <= 8'h00;
         rsp_denied <= 1'b0;
      end else if (take && deny) begin
         // Blocked reads see a fixed code, never the array
         rsp_valid  <= 1'b1;
         rsp_data   <= FSP_BLOCK_DATA;
         rsp_denied <= 1'b1;
      end else if (busy_q && fl_done) begin
         rsp_valid  <= 1'b1;
         rsp_data   <= rd_pend_q ? fl_rdata : FSP_BLOCK_DATA;
         rsp_denied <= 1'b0;
      end else begin
         rsp_valid  <= 1'b0;
         rsp_denied <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Security error flag: a new violation beats a clear
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         flash_security_error_flag <= 1'b0;
      else if (take && deny)
         flash_security_error_flag <= 1'b1;
      else if (sec_err_clr)
         flash_security_error_flag <= 1'b0;
   end

   // Ready only after the load, and while no request is in flight
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         req_ready <= 1'b0;
      else
         req_ready <= running && !busy_q && !(take && !deny);
   end

endmodule

// ---- test/fsp_chk_sva.sv ----
// Port checker for the flash sector protection top
module fsp_chk
   import fsp_pkg::*;
#(
   parameter int unsigned SECTORS = 8
)(
   input wire logic                           clk,
   input wire logic                           rst_n,
   input wire logic                           req_valid,
   input wire fsp_pkg::fsp_path_t             req_path,
   input wire fsp_pkg::fsp_op_t               req_op,
   input wire logic                           req_ready,
   input wire logic                           fl_valid,
   input wire logic [fsp_pkg::FSP_ADDR_W-1:0] fl_addr,
   input wire fsp_pkg::fsp_op_t               fl_op,
   input wire logic                           fl_done,
   input wire logic [7:0]                     fl_rdata,
   input wire logic                           rsp_valid,
   input wire logic [7:0]                     rsp_data,
   input wire logic                           rsp_denied,
   input wire logic                           flash_security_error_flag,
   input wire logic                           sec_err_clr,
   input wire logic                           id_rd,
   input wire logic                           load_done
);
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------
   // One clock domain, so clocking and disable are set once
   // ----------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_take;   // Request accepted at this edge
      req_valid && req_ready;
   endsequence
   sequence s_deny;   // Refusal answer
      rsp_valid && rsp_denied;
   endsequence
   deny_zero_a: assert property (s_deny |-> rsp_data == 8'h00)
      else $error("refused answer carries data");
   deny_flag_a: assert property (s_deny |-> flash_security_error_flag)
      else $error("refusal without error flag");
   flag_sticky_a: assert property (flash_security_error_flag && !sec_err_clr
      |=> flash_security_error_flag)
      else $error("error flag dropped without clear");
   flag_clear_a: assert property ($fell(flash_security_error_flag)
      |-> $past(sec_err_clr))
      else $error("error flag fell without clear");
   fetch_free_a: assert property (s_take ##0 req_path == FSP_PATH_FETCH
      |=> fl_valid && !rsp_valid)
      else $error("fetch was not forwarded");
   icp_read_a: assert property (s_take ##0 (req_path == FSP_PATH_ICP &&
      req_op == FSP_OP_READ) |=> s_deny)
      else $error("programmer read not refused");
   read_pass_a: assert property (fl_valid && fl_done && fl_op == FSP_OP_READ
      |=> rsp_valid && !rsp_denied && rsp_data == $past(fl_rdata))
      else $error("read data not passed back");
   fl_hold_a: assert property (fl_valid && !fl_done
      |=> fl_valid && $stable(fl_addr) && $stable(fl_op))
      else $error("flash request changed before done");
   load_gate_a: assert property (!load_done |-> !req_ready)
      else $error("ready before inhibit load");
   load_time_a: assert property ($rose(rst_n) |-> ##[1:40] load_done)
      else $error("inhibit load too slow");
   id_quiet_a: assert property (load_done |-> !id_rd)
      else $error("ID block read after load");
endmodule

bind fsp_top fsp_chk #(.SECTORS(SECTORS)) fsp_chk_inst (.clk(clk),
   .rst_n(rst_n), .req_valid(req_valid), .req_path(req_path),
   .req_op(req_op), .req_ready(req_ready), .fl_valid(fl_valid),
   .fl_addr(fl_addr), .fl_op(fl_op), .fl_done(fl_done),
   .fl_rdata(fl_rdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
   .rsp_denied(rsp_denied), .sec_err_clr(sec_err_clr),
   .flash_security_error_flag(flash_security_error_flag),
   .id_rd(id_rd), .load_done(load_done));

// ---- test/fsp_far_mdl.sv ----
// Flash array and ID block model on the far side of the checker
module fsp_far_mdl
   import fsp_pkg::*;
(
   input  wire logic                           clk,
   input  wire logic                           rst_n,
   input  wire logic                           fl_valid,
   input  wire logic [fsp_pkg::FSP_ADDR_W-1:0] fl_addr,
   input  wire fsp_pkg::fsp_op_t               fl_op,
   output logic                                fl_done,
   output logic [7:0]                          fl_rdata,
   input  wire logic                           id_rd,
   input  wire logic [fsp_pkg::FSP_ID_W-1:0]   id_addr,
   output logic [7:0]                          id_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] id_mem [64];  // Separate 64-byte ID block
   logic [1:0] wait_q;       // Cycles spent on the current op
   logic [7:0] junk_q;       // Toggling filler between strobes
   wire  [1:0] lat = fl_addr[0] ? 2'h3 : 2'h0;  // Odd addresses are slow
   wire        busy = fl_valid && !fl_done;
   // Array answers; idle data toggles so stale bytes never look valid
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wait_q   <= 2'h0;
         fl_done  <= 1'b0;
         fl_rdata <= 8'h00;
      end else if (busy && wait_q == lat) begin
         wait_q   <= 2'h0;
         fl_done  <= 1'b1;
         fl_rdata <= fl_addr[7:0] ^ 8'h3c;
      end else begin
         wait_q   <= busy ? wait_q + 2'h1 : 2'h0;
         fl_done  <= 1'b0;
         fl_rdata <= ~fl_rdata;
      end
   end
   // ID byte stands while the strobe is high, toggling otherwise,
   // because the loader captures at the edge that ends the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         junk_q <= 8'h00;
      else
         junk_q <= ~junk_q;
   end
   assign id_rdata = id_rd ? id_mem[id_addr] : junk_q;
   // Whole-chip erase also wipes the ID block
   always @(posedge clk) begin
      if (fl_done && fl_op == FSP_OP_CHIPERS)
         for (int i = 0; i < 64; i++)
            id_mem[i] = 8'hff;
   end
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the flash sector protection checker
module tb_top;
   import fsp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, sec_err_clr = 1'b0;
   logic dbg = 1'b0, inj = 1'b0;
   logic [13:0] req_addr = 14'h0000;
   fsp_path_t   req_path = FSP_PATH_IAP;
   fsp_op_t     req_op = FSP_OP_READ;
   logic req_ready, fl_valid, fl_done, rsp_valid, rsp_denied, flag;
   logic id_rd, load_done;
   logic [13:0] fl_addr;
   fsp_op_t     fl_op;
   logic [7:0]  fl_rdata, rsp_data, id_rdata;
   logic [5:0]  id_addr;
   int n_errors = 0;
   int comparisons = 0;
   // Sector images: odd values sit next to 0xff to catch loose tests
   localparam logic [7:0] PE_IMG [8] = '{8'hff, 8'h00, 8'hff, 8'h00,
      8'hff, 8'hff, 8'hff, 8'hfe};
   localparam logic [7:0] AC_IMG [8] = '{8'hff, 8'hff, 8'h5a, 8'h00,
      8'hff, 8'h01, 8'hfe, 8'hff};
   fsp_top #(.SECTORS(8)) fsp_top_inst (.clk(clk), .rst_n(rst_n),
      .req_valid(req_valid), .req_addr(req_addr), .req_path(req_path),
      .req_op(req_op), .on_chip_debug_mode(dbg),
      .debug_injected_instruction(inj), .req_ready(req_ready),
      .fl_valid(fl_valid), .fl_addr(fl_addr), .fl_op(fl_op),
      .fl_done(fl_done), .fl_rdata(fl_rdata), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_denied(rsp_denied),
      .flash_security_error_flag(flag), .sec_err_clr(sec_err_clr),
      .id_rd(id_rd), .id_addr(id_addr), .id_rdata(id_rdata),
      .load_done(load_done));
   fsp_far_mdl fsp_far_mdl_inst (.clk(clk), .rst_n(rst_n),
      .fl_valid(fl_valid), .fl_addr(fl_addr), .fl_op(fl_op),
      .fl_done(fl_done), .fl_rdata(fl_rdata), .id_rd(id_rd),
      .id_addr(id_addr), .id_rdata(id_rdata));
   always #25 clk = ~clk;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Reset, then wait for the inhibit load to finish
   task automatic restart();
      int k;
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         #1;
         k++;
      end while (load_done !== 1'b1 && k < 100);
      check({7'h0, load_done}, 8'h01);
   endtask
   // One request; f = {debug mode, injected, refusal expected}
   task automatic req(input logic [13:0] a, input fsp_path_t p,
      input fsp_op_t o, input logic [2:0] f);
      int k;
      logic [7:0] ed;
      ed = (f[0] || o != FSP_OP_READ) ? 8'h00 : a[7:0] ^ 8'h3c;
      k = 0;
      while (req_ready !== 1'b1 && k < 200) begin
         @(posedge clk);
         #1;
         k++;
      end
      @(posedge clk);
      {req_valid, req_addr, req_path, req_op} <= {1'b1, a, p, o};
      {dbg, inj} <= f[2:1];
      @(posedge clk);
      req_valid <= 1'b0;
      // A refusal answers at this very edge and stands one cycle
      #1;
      k = 0;
      while (rsp_valid !== 1'b1 && k < 200) begin
         @(posedge clk);
         #1;
         k++;
      end
      check({7'h0, rsp_valid}, 8'h01);
      check({7'h0, rsp_denied}, {7'h0, f[0]});
      check(rsp_data, ed);
   endtask
   task automatic t_open();
      req(14'h0005, FSP_PATH_IAP, FSP_OP_READ, 3'b000);
      req(14'h0006, FSP_PATH_TABLE, FSP_OP_READ, 3'b000);
      req(14'h0007, FSP_PATH_IAP, FSP_OP_PROG, 3'b110);
      req(14'h0008, FSP_PATH_ICP, FSP_OP_ERASE, 3'b000);
   endtask
   task automatic t_pe();
      req(14'h0800, FSP_PATH_ICP, FSP_OP_PROG, 3'b001);
      req(14'h0801, FSP_PATH_IAP, FSP_OP_ERASE, 3'b111);
      req(14'h0802, FSP_PATH_TABLE, FSP_OP_READ, 3'b111);
      req(14'h0803, FSP_PATH_IAP, FSP_OP_PROG, 3'b000);
      req(14'h0804, FSP_PATH_TABLE, FSP_OP_READ, 3'b000);
      req(14'h0805, FSP_PATH_IAP, FSP_OP_PROG, 3'b100);
   endtask
   task automatic t_acc();
      req(14'h1001, FSP_PATH_IAP, FSP_OP_READ, 3'b001);
      req(14'h1002, FSP_PATH_IAP, FSP_OP_ERASE, 3'b001);
      req(14'h1003, FSP_PATH_TABLE, FSP_OP_READ, 3'b001);
      req(14'h1004, FSP_PATH_ICP, FSP_OP_PROG, 3'b001);
      req(14'h1005, FSP_PATH_IAP, FSP_OP_PROG, 3'b111);
      req(14'h1006, FSP_PATH_FETCH, FSP_OP_READ, 3'b000);
      req(14'h1007, FSP_PATH_IAP, FSP_OP_READ, 3'b100);
      req(14'h1800, FSP_PATH_IAP, FSP_OP_PROG, 3'b001);
      req(14'h2801, FSP_PATH_IAP, FSP_OP_READ, 3'b001);
      req(14'h2000, FSP_PATH_IAP, FSP_OP_READ, 3'b000);
      req(14'h3800, FSP_PATH_ICP, FSP_OP_PROG, 3'b001);
      req(14'h3000, FSP_PATH_IAP, FSP_OP_READ, 3'b001);
      req(14'h0009, FSP_PATH_ICP, FSP_OP_READ, 3'b001);
      req(14'h000b, FSP_PATH_ICP, FSP_OP_READ, 3'b101);
   endtask
   // Flag stays until cleared, and only a refusal sets it again
   task automatic t_flag();
      check({7'h0, flag}, 8'h01);
      @(posedge clk);
      sec_err_clr <= 1'b1;
      @(posedge clk);
      sec_err_clr <= 1'b0;
      req(14'h000a, FSP_PATH_IAP, FSP_OP_READ, 3'b000);
      check({7'h0, flag}, 8'h00);
      req(14'h1009, FSP_PATH_TABLE, FSP_OP_READ, 3'b001);
      check({7'h0, flag}, 8'h01);
   endtask
   // Programmer whole-chip erase lifts protection, also after reload
   task automatic t_wipe();
      req(14'h0000, FSP_PATH_ICP, FSP_OP_CHIPERS, 3'b000);
      req(14'h100a, FSP_PATH_IAP, FSP_OP_READ, 3'b000);
      restart();
      req(14'h100b, FSP_PATH_TABLE, FSP_OP_READ, 3'b000);
   endtask
   // Watchdog far beyond the expected run length
   initial begin
      #2000000;
      n_errors++;
      close_out();
   end
   initial begin
      for (int i = 0; i < 64; i++)
         fsp_far_mdl_inst.id_mem[i] = 8'hff;
      for (int i = 0; i < 8; i++) begin
         fsp_far_mdl_inst.id_mem[i] = PE_IMG[i];
         fsp_far_mdl_inst.id_mem[i + 16] = AC_IMG[i];
      end
      restart();
      t_open();
      t_pe();
      t_acc();
      t_flag();
      t_wipe();
      close_out();
   end
endmodule
